// >>> design/hcc_pkg.sv
// constants and carrier types shared by the cascade chain design files
// assumes one 100 MHz clock and a synchronous active-high reset
package hcc_pkg;

    // ------------------------------------------------------------
    // cascade geometry
    // ------------------------------------------------------------
    localparam int MAX_CHIPS     = 9;
    localparam int N_SAT         = 7;
    localparam int N_PORT        = 8;
    localparam int MAX_SAT_PORTS = 63;

    // ------------------------------------------------------------
    // clock divider
    // ------------------------------------------------------------
    localparam int         DIV_W      = 7;
    localparam logic [1:0] SHIFT_HH   = 2'h0;
    localparam logic [1:0] SHIFT_HL   = 2'h1;
    localparam logic [1:0] SHIFT_LH   = 2'h2;
    localparam logic [1:0] SHIFT_LL   = 2'h3;
    localparam logic [2:0] OFS_CLK_B  = 3'h2;
    localparam logic [2:0] OFS_CLK_C  = 3'h3;

    // ------------------------------------------------------------
    // timing in short pulse periods (edges of the cascade clock b)
    // ------------------------------------------------------------
    localparam int                IDLE_W         = 4;
    localparam logic [IDLE_W-1:0] IDLE_EDGES     = 4'h8;
    localparam int                RUN_W          = 2;
    localparam logic [RUN_W-1:0]  RUN_ERR        = 2'h3;
    localparam int                MON_W          = 20;
    localparam logic [MON_W-1:0]  MON_EDGES_DEF  = 20'h7_A120;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic enable;
        logic pri_flag;
        logic data;
        logic hold;
    } hcc_fwd_t;

    typedef struct packed {
        logic enable;
        logic pri_flag;
        logic data;
    } hcc_rev_t;

    typedef enum logic [2:0] {
        HCC_IDLE,
        HCC_FWD_TOP,
        HCC_FWD_PASS,
        HCC_UP_OWN,
        HCC_UP_PASS
    } hcc_mode_t;

endpackage

// >>> design/hcc_sync.sv
// two flip-flop synchroniser for a group of pin inputs
// assumes inputs are asynchronous to clk_i
`timescale 1ns/100ps
`default_nettype none
module hcc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } hcc_sync_state_t;

    hcc_sync_state_t s_q;
    hcc_sync_state_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.meta = async_i;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_o = s_q.sync;
endmodule
`default_nettype wire

// >>> design/hcc_clkgen.sv
// cascade clock divider: three related clocks from the main clock
// assumes baud select already synchronised; outputs held low off the top chip
`timescale 1ns/100ps
`default_nettype none
module hcc_clkgen (
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic       is_top_i,
    input  wire logic [1:0] baud_sel_i,
    output logic      [2:0] casc_clk_o
);
    typedef struct packed {
        logic [hcc_pkg::DIV_W-1:0] cnt;
        logic [2:0]                clk;
    } hcc_clkgen_state_t;

    hcc_clkgen_state_t s_q;
    hcc_clkgen_state_t s_d;
    logic [1:0]        shift;

    always_comb begin
        unique case (baud_sel_i)
            2'h3:    shift = hcc_pkg::SHIFT_HH;
            2'h2:    shift = hcc_pkg::SHIFT_HL;
            2'h1:    shift = hcc_pkg::SHIFT_LH;
            default: shift = hcc_pkg::SHIFT_LL;
        endcase
    end

    always_comb begin
        s_d     = s_q;
        s_d.cnt = s_q.cnt + 1'b1;
        // top chip makes the cascade clocks
        s_d.clk[0] = is_top_i & s_d.cnt[shift];
        s_d.clk[1] = is_top_i & s_d.cnt[3'({1'b0, shift}) + hcc_pkg::OFS_CLK_B];
        s_d.clk[2] = is_top_i & s_d.cnt[3'({1'b0, shift}) + hcc_pkg::OFS_CLK_C];
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign casc_clk_o = s_q.clk;
endmodule
`default_nettype wire

// >>> design/hcc_chain.sv
// cascade chain logic of one hub chip: forward and reverse relay, port
// repeat, cascade clock source and receive/error monitors
// assumes all pin inputs are asynchronous; cascade clock b is sampled, not used as a clock
//
// What this block does
// - chain reaches nine chips, sixty-three satellite ports
// - priority descends down chain; top port 0 center
// - center packet repeated on all satellite ports
// - forward data NRZ, shortest pulse two periods
// - forward enable, priority, hold high while relaying
// - satellite packets travel up to center port
// - reverse data NRZ, shortest pulse two periods
// - reverse enable high while relaying upward
// - forward outputs low when not relaying
// - reverse outputs low when not relaying
// - top chip generates clocks, sets baud rate
// - monitors react to own port receives only
// - simultaneous satellite packets: lowest port wins
`timescale 1ns/100ps
`default_nettype none
module hcc_chain #(
    parameter logic [hcc_pkg::MON_W-1:0] MON_EDGES = hcc_pkg::MON_EDGES_DEF
) (
    input  wire logic                       clk_i,
    input  wire logic                       srst_i,
    input  wire logic                       baud_select_low_i,
    input  wire logic                       baud_select_high_i,
    input  wire logic                       duplex_select_i,
    input  wire logic                       cascade_clock_in_a_i,
    input  wire logic                       cascade_clock_in_b_i,
    input  wire logic                       cascade_clock_in_c_i,
    output logic                            cascade_clock_out_a_o,
    output logic                            cascade_clock_out_b_o,
    output logic                            cascade_clock_out_c_o,
    input  wire logic                       center_rx_data_i,
    output logic                            center_tx_enable_o,
    output logic                            center_tx_data_o,
    input  wire logic [hcc_pkg::N_SAT-1:0]  sat_rx_data_i,
    output logic      [hcc_pkg::N_SAT-1:0]  sat_tx_enable_o,
    output logic      [hcc_pkg::N_SAT-1:0]  sat_tx_data_o,
    input  wire hcc_pkg::hcc_fwd_t          fwd_in_i,
    output hcc_pkg::hcc_fwd_t               fwd_out_o,
    input  wire hcc_pkg::hcc_rev_t          rev_in_i,
    output hcc_pkg::hcc_rev_t               rev_out_o,
    output logic                            rx_monitor_n_o,
    output logic                            err_monitor_n_o,
    output logic                            is_top_o
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int SYNC_W = 19;

    logic [SYNC_W-1:0] pins_async;
    logic [SYNC_W-1:0] pins;

    assign pins_async = {baud_select_high_i, baud_select_low_i, duplex_select_i,
                         cascade_clock_in_b_i, rev_in_i, fwd_in_i,
                         sat_rx_data_i, center_rx_data_i};

    hcc_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .async_i (pins_async),
        .sync_o  (pins)
    );

    logic                      rx0_s;
    logic [hcc_pkg::N_SAT-1:0] sat_s;
    hcc_pkg::hcc_fwd_t         fwd_s;
    hcc_pkg::hcc_rev_t         rev_s;
    logic                      lclk_s;
    logic                      full_dup_s;
    logic [1:0]                baud_s;

    assign {baud_s, full_dup_s, lclk_s, rev_s, fwd_s, sat_s, rx0_s} = pins;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic                                            lclk_prev;
        logic                                            phase;
        logic                                            top;
        hcc_pkg::hcc_mode_t                              mode;
        logic [2:0]                                      sel;
        logic [hcc_pkg::N_PORT-1:0][hcc_pkg::IDLE_W-1:0] idle;
        logic [hcc_pkg::N_PORT-1:0][hcc_pkg::RUN_W-1:0]  run;
        logic [hcc_pkg::N_PORT-1:0]                      act_prev;
        hcc_pkg::hcc_fwd_t                               fwd;
        hcc_pkg::hcc_rev_t                               rev;
        logic [hcc_pkg::N_SAT-1:0]                       sat_en;
        logic [hcc_pkg::N_SAT-1:0]                       sat_dat;
        logic                                            ctx_en;
        logic                                            ctx_dat;
        logic [hcc_pkg::MON_W-1:0]                       rx_cnt;
        logic [hcc_pkg::MON_W-1:0]                       err_cnt;
    } hcc_state_t;

    hcc_state_t s_q;
    hcc_state_t s_d;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // lowest numbered active satellite port
    function automatic logic [2:0] lowest_port(input logic [hcc_pkg::N_SAT-1:0] act);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = hcc_pkg::N_SAT - 1; i >= 0; i--) begin
            if (act[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic [hcc_pkg::MON_W-1:0] retrigger(input logic                      hit,
                                                           input logic                      edge_en,
                                                           input logic [hcc_pkg::MON_W-1:0] cnt);
        logic [hcc_pkg::MON_W-1:0] nxt;
        nxt = cnt;
        if (hit) begin
            nxt = MON_EDGES;
        end else if (edge_en && cnt != '0) begin
            nxt = cnt - 1'b1;
        end
        return nxt;
    endfunction

    logic                       link_edge;
    logic                       bit_en;
    logic [hcc_pkg::N_PORT-1:0] rx_all;
    logic [hcc_pkg::N_PORT-1:0] rx_mask;
    logic [hcc_pkg::N_PORT-1:0] active;
    logic [hcc_pkg::N_PORT-1:0] err_hit;
    logic [hcc_pkg::N_SAT-1:0]  sat_act;
    logic                       top_now;

    // all forward inputs low marks the top chip
    assign top_now   = (fwd_s == '0);
    assign link_edge = lclk_s & ~s_q.lclk_prev;
    // data changes on every second short period
    assign bit_en    = link_edge & s_q.phase;
    assign rx_all    = {sat_s, rx0_s & s_q.top};
    // in half duplex a port ignores its line while it transmits
    assign rx_mask   = full_dup_s ? rx_all : rx_all & ~{s_q.sat_en, s_q.ctx_en};

    // ------------------------------------------------------------
    // per port activity and error detection
    // ------------------------------------------------------------
    // center port plus seven satellite ports per chip
    for (genvar p = 0; p < hcc_pkg::N_PORT; p++) begin : g_port
        assign active[p]  = s_q.idle[p] < hcc_pkg::IDLE_EDGES;
        assign err_hit[p] = link_edge & rx_mask[p] & (s_q.run[p] == hcc_pkg::RUN_ERR);
    end

    assign sat_act = active[hcc_pkg::N_PORT-1:1];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d           = s_q;
        s_d.lclk_prev = lclk_s;
        s_d.top       = top_now;
        s_d.act_prev  = active;
        if (link_edge) begin
            s_d.phase = ~s_q.phase;
        end

        for (int p = 0; p < hcc_pkg::N_PORT; p++) begin
            if (rx_mask[p]) begin
                s_d.idle[p] = '0;
            end else if (link_edge && s_q.idle[p] != hcc_pkg::IDLE_EDGES) begin
                s_d.idle[p] = s_q.idle[p] + 1'b1;
            end
            if (!rx_mask[p]) begin
                s_d.run[p] = '0;
            end else if (link_edge && s_q.run[p] != hcc_pkg::RUN_ERR) begin
                s_d.run[p] = s_q.run[p] + 1'b1;
            end
        end

        // center traffic first, then chain order
        unique case (s_q.mode)
            hcc_pkg::HCC_IDLE: begin
                if (s_q.top && active[0]) begin
                    s_d.mode = hcc_pkg::HCC_FWD_TOP;
                end else if (!s_q.top && fwd_s.enable) begin
                    s_d.mode = hcc_pkg::HCC_FWD_PASS;
                end else if (sat_act != '0) begin
                    s_d.mode = hcc_pkg::HCC_UP_OWN;
                    s_d.sel  = lowest_port(sat_act);
                end else if (rev_s.enable) begin
                    s_d.mode = hcc_pkg::HCC_UP_PASS;
                end
            end
            hcc_pkg::HCC_FWD_TOP: begin
                if (!active[0]) begin
                    s_d.mode = hcc_pkg::HCC_IDLE;
                end
            end
            hcc_pkg::HCC_FWD_PASS: begin
                if (!fwd_s.enable) begin
                    s_d.mode = hcc_pkg::HCC_IDLE;
                end
            end
            hcc_pkg::HCC_UP_OWN: begin
                if (!sat_act[s_q.sel]) begin
                    s_d.mode = hcc_pkg::HCC_IDLE;
                end
            end
            hcc_pkg::HCC_UP_PASS: begin
                if (!rev_s.enable) begin
                    s_d.mode = hcc_pkg::HCC_IDLE;
                end
            end
            default: begin
                s_d.mode = hcc_pkg::HCC_IDLE;
            end
        endcase

        // outputs follow the mode just chosen
        // forward chain idles low
        s_d.fwd    = '0;
        s_d.rev    = '0;
        s_d.sat_en = '0;
        s_d.ctx_en = 1'b0;
        unique case (s_d.mode)
            hcc_pkg::HCC_FWD_TOP, hcc_pkg::HCC_FWD_PASS: begin
                // repeat locally and send down the chain
                s_d.sat_en  = '1;
                s_d.sat_dat = {hcc_pkg::N_SAT{(s_d.mode == hcc_pkg::HCC_FWD_TOP) ? rx0_s : fwd_s.data}};
                s_d.fwd.enable   = 1'b1;
                s_d.fwd.pri_flag = 1'b1;
                s_d.fwd.hold     = 1'b1;
                s_d.fwd.data     = bit_en ? s_d.sat_dat[0] : s_q.fwd.data;
            end
            hcc_pkg::HCC_UP_OWN: begin
                if (s_q.top) begin
                    // own satellite packet to the center port
                    s_d.ctx_en  = 1'b1;
                    s_d.ctx_dat = sat_s[s_d.sel];
                end else begin
                    s_d.rev.enable   = 1'b1;
                    s_d.rev.pri_flag = 1'b1;
                    // reverse data retimed to two periods
                    s_d.rev.data     = bit_en ? sat_s[s_d.sel] : s_q.rev.data;
                end
            end
            hcc_pkg::HCC_UP_PASS: begin
                if (s_q.top) begin
                    // relayed packet leaves the center port
                    s_d.ctx_en  = 1'b1;
                    s_d.ctx_dat = rev_s.data;
                end else begin
                    s_d.rev.enable   = 1'b1;
                    s_d.rev.pri_flag = rev_s.pri_flag;
                    // reverse data retimed to two periods
                    s_d.rev.data     = bit_en ? rev_s.data : s_q.rev.data;
                end
            end
            default: begin
            end
        endcase
        s_d.fwd.data = s_d.fwd.data & s_d.fwd.enable;
        s_d.rev.data = s_d.rev.data & s_d.rev.enable;
        s_d.sat_dat  = s_d.sat_dat & s_d.sat_en;
        s_d.ctx_dat  = s_d.ctx_dat & s_d.ctx_en;

        // monitors see own port receptions only
        s_d.rx_cnt  = retrigger((active & ~s_q.act_prev) != '0, link_edge, s_q.rx_cnt);
        s_d.err_cnt = retrigger(err_hit != '0, link_edge, s_q.err_cnt);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_q         <= '0;
            s_q.mode    <= hcc_pkg::HCC_IDLE;
            s_q.top     <= 1'b1;
            s_q.idle    <= {hcc_pkg::N_PORT{hcc_pkg::IDLE_EDGES}};
            // lamp test: monitors lit through reset and after it
            s_q.rx_cnt  <= MON_EDGES;
            s_q.err_cnt <= MON_EDGES;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // cascade clock source
    // ------------------------------------------------------------
    logic [2:0] casc_clk;

    hcc_clkgen u_clkgen (
        .clk_i      (clk_i),
        .srst_i     (srst_i),
        .is_top_i   (s_q.top),
        .baud_sel_i (baud_s),
        .casc_clk_o (casc_clk)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign {cascade_clock_out_c_o, cascade_clock_out_b_o, cascade_clock_out_a_o} = casc_clk;

    assign fwd_out_o          = s_q.fwd;
    assign rev_out_o          = s_q.rev;
    assign sat_tx_enable_o    = s_q.sat_en;
    assign sat_tx_data_o      = s_q.sat_dat;
    assign center_tx_enable_o = s_q.ctx_en;
    assign center_tx_data_o   = s_q.ctx_dat;
    assign rx_monitor_n_o     = (s_q.rx_cnt == '0);
    assign err_monitor_n_o    = (s_q.err_cnt == '0);
    assign is_top_o           = s_q.top;
endmodule
`default_nettype wire

// >>> verif/hcc_chain_props.sv
// properties of one cascade chain chip, seen at its ports
// bound from the bench top; one clock, sync reset
`timescale 1ns/100ps
`default_nettype none
module hcc_chain_props (
    input wire logic              clk_i,
    input wire logic              srst_i,
    input wire logic [6:0]        sat_rx_data_i,
    input wire logic [6:0]        sat_tx_enable_o,
    input wire logic              center_tx_enable_o,
    input wire logic              cascade_clock_out_b_o,
    input wire hcc_pkg::hcc_fwd_t fwd_in_i,
    input wire hcc_pkg::hcc_fwd_t fwd_out_o,
    input wire hcc_pkg::hcc_rev_t rev_out_o,
    input wire logic              rx_monitor_n_o,
    input wire logic              is_top_o
);
// ----------------
// chain properties
// ----------------
default clocking @(posedge clk_i); endclocking
default disable iff (srst_i);
a_fwd_idle_low: assert property (!fwd_out_o.enable |-> fwd_out_o == '0)
    else $error("fwd out busy while idle");
a_rev_idle_low: assert property (!rev_out_o.enable |-> rev_out_o == '0)
    else $error("rev out busy while idle");
a_fwd_ctl_high: assert property (fwd_out_o.enable |-> fwd_out_o.pri_flag && fwd_out_o.hold)
    else $error("fwd status low in relay");
a_top_repeat: assert property (is_top_o && fwd_out_o.enable |-> sat_tx_enable_o == 7'h7f)
    else $error("center packet not repeated");
a_fwd_bit_len: assert property (fwd_out_o.enable && $changed(fwd_out_o.data) |=> $stable(fwd_out_o.data)[*8])
    else $error("fwd data pulse short");
a_rev_bit_len: assert property (rev_out_o.enable && $changed(rev_out_o.data) |=> $stable(rev_out_o.data)[*8])
    else $error("rev data pulse short");
a_top_detect: assert property ((fwd_in_i == '0)[*6] |-> is_top_o)
    else $error("top not detected");
a_clk_quiet: assert property (!is_top_o[*4] |-> !cascade_clock_out_b_o)
    else $error("clock out on lower chip");
a_rx_mon_lit: assert property ($rose(|sat_rx_data_i) |-> ##[1:6] !rx_monitor_n_o)
    else $error("receive monitor not lit");
c_fwd: cover property (is_top_o && fwd_out_o.enable);
c_rev: cover property (rev_out_o.enable);
c_ctr: cover property (center_tx_enable_o);
endmodule
`default_nettype wire

// >>> verif/hcc_peer_model.sv
// neighbour chip model: upper chip on the forward chain, lower on the reverse
// makes the shared link clock; chain lines low when not sending, except forward hold while parked
`timescale 1ns/100ps
`default_nettype none
module hcc_peer_model (
    output logic              link_clk_o,
    output hcc_pkg::hcc_fwd_t fwd_o,
    output hcc_pkg::hcc_rev_t rev_o
);
// ------------------
// link clock, chains
// ------------------
// idle low, shared clock
initial begin
    link_clk_o = 1'b0;
    fwd_o = '0;
    rev_o = '0;
    forever #80 link_clk_o = ~link_clk_o;
end
task automatic send(input logic up, input logic [7:0] bits);
    for (int i = 7; i >= 0; i--) begin
        repeat (2) @(posedge link_clk_o);
        if (up) rev_o <= {1'b1, 1'b1, bits[i]};
        else fwd_o <= {1'b1, 1'b1, bits[i], 1'b1};
    end
    repeat (2) @(posedge link_clk_o);
    fwd_o <= '0;
    rev_o <= '0;
endtask
task automatic park(input logic on);
    @(posedge link_clk_o);
    fwd_o.hold <= on;
endtask
endmodule
`default_nettype wire

// >>> verif/tb.sv
// bench top: one chain chip with a neighbour model on both chains
// the neighbour makes the link clock; all checks run from here
`timescale 1ns/100ps
`default_nettype none
module tb;
logic              clk, srst, crx, link, clk_b, ctx_en, ctx_dat, rx_n, err_n, top, dup, clk_a, clk_c;
logic [1:0]        bsel;
logic [6:0]        srx, stx_en, stx_dat;
hcc_pkg::hcc_fwd_t fwd_in, fwd_out;
hcc_pkg::hcc_rev_t rev_in, rev_out;
int                miscompares, cmp_count, cycles;
// -------
// harness
// -------
hcc_peer_model hcc_peer_model_inst (.link_clk_o(link), .fwd_o(fwd_in), .rev_o(rev_in));
hcc_chain #(.MON_EDGES(20'h0_0014)) hcc_chain_inst (
    .clk_i(clk), .srst_i(srst), .baud_select_low_i(bsel[0]), .baud_select_high_i(bsel[1]),
    .duplex_select_i(dup), .cascade_clock_in_a_i(1'b0), .cascade_clock_in_b_i(link),
    .cascade_clock_in_c_i(1'b0), .cascade_clock_out_a_o(clk_a), .cascade_clock_out_b_o(clk_b),
    .cascade_clock_out_c_o(clk_c), .center_rx_data_i(crx), .center_tx_enable_o(ctx_en),
    .center_tx_data_o(ctx_dat), .sat_rx_data_i(srx), .sat_tx_enable_o(stx_en),
    .sat_tx_data_o(stx_dat), .fwd_in_i(fwd_in), .fwd_out_o(fwd_out), .rev_in_i(rev_in),
    .rev_out_o(rev_out), .rx_monitor_n_o(rx_n), .err_monitor_n_o(err_n), .is_top_o(top));
initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
end
always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
        miscompares++;
        tally_and_finish();
    end
end
task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
        miscompares++;
        $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
endtask
task automatic tick(input int n);
    repeat (n) @(posedge clk);
endtask
// one bit lasts two link periods
task automatic rx_bits(input int port, input logic [7:0] bits);
    for (int i = 7; i >= 0; i--) begin
        if (port == 0) crx <= bits[i];
        else srx[port-1] <= bits[i];
        tick(32);
    end
endtask
// -----
// tests
// -----
task automatic t_reset();
    srst <= 1'b1;
    tick(8);
    chk("chains", 8'h00, 8'({fwd_out, rev_out}));
    chk("is_top", 8'h01, 8'(top));
    srst <= 1'b0;
    tick(2);
    $display("t_reset done");
endtask
task automatic t_clocks();
    int n, na, nc;
    logic p, pa, pc;
    for (int s = 0; s < 4; s++) begin
        bsel <= 2'(3 - s);
        tick(16);
        n = 0;
        na = 0;
        nc = 0;
        repeat (128) begin
            p = clk_b;
            pa = clk_a;
            pc = clk_c;
            @(posedge clk);
            if (clk_b && !p) n++;
            if (clk_a && !pa) na++;
            if (clk_c && !pc) nc++;
        end
        chk("clock_b rises", 8'(16 >> s), 8'(n));
        chk("clock_a rises", 8'(64 >> s), 8'(na));
        chk("clock_c rises", 8'(8 >> s), 8'(nc));
    end
    bsel <= 2'h3;
    $display("t_clocks done");
endtask
task automatic t_center();
    fork
        rx_bits(0, 8'h66);
        begin
            tick(80);
            chk("sat_tx", 8'h7f, 8'(stx_en & stx_dat));
            chk("fwd ctl", 8'h07, 8'({fwd_out.enable, fwd_out.pri_flag, fwd_out.hold}));
        end
    join
    tick(200);
    chk("fwd idle", 8'h00, 16'({fwd_out, stx_en}));
    $display("t_center done");
endtask
task automatic t_half();
    dup <= 1'b0;
    tick(4);
    fork
        rx_bits(0, 8'hf0);
        rx_bits(1, 8'h3c);
    join
    tick(30);
    chk("half dup ctx,sat", 8'h00, 16'({ctx_en, stx_en}));
    dup <= 1'b1;
    tick(10);
    $display("t_half done");
endtask
task automatic t_up_top();
    fork
        rx_bits(2, 8'ha0);
        rx_bits(5, 8'hc0);
        begin
            tick(50);
            chk("center en,data", 8'h02, 8'({ctx_en, ctx_dat}));
        end
    join
    tick(200);
    $display("t_up_top done");
endtask
task automatic t_monitors();
    tick(400);
    chk("monitors", 8'h03, 8'({rx_n, err_n}));
    fork
        hcc_peer_model_inst.send(1'b1, 8'h66);
        begin
            tick(200);
            chk("center en", 8'h01, 8'(ctx_en));
        end
    join
    chk("monitors", 8'h03, 8'({rx_n, err_n}));
    rx_bits(7, 8'hf0);
    chk("monitors", 8'h00, 8'({rx_n, err_n}));
    $display("t_monitors done");
endtask
task automatic t_lower();
    // center receive held low off the top
    fork
        hcc_peer_model_inst.send(1'b0, 8'h66);
        begin
            tick(160);
            chk("top,sat,center", 16'h00fe, 16'({top, stx_en, ctx_en}));
            chk("fwd ctl", 8'h07, 8'({fwd_out.enable, fwd_out.pri_flag, fwd_out.hold}));
        end
    join
    hcc_peer_model_inst.park(1'b1);
    fork
        rx_bits(3, 8'h66);
        begin
            tick(80);
            chk("top,rev,center", 8'h06, 8'({top, rev_out.enable, rev_out.pri_flag, ctx_en}));
        end
    join
    tick(200);
    chk("rev idle", 8'h00, 8'(rev_out));
    hcc_peer_model_inst.park(1'b0);
    $display("t_lower done");
endtask
task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
endtask
initial begin
    srst = 1'b1;
    bsel = 2'h3;
    dup = 1'b1;
    crx = 1'b0;
    srx = 7'h00;
    t_reset();
    t_clocks();
    t_center();
    t_half();
    t_up_top();
    t_monitors();
    t_lower();
    tally_and_finish();
end
endmodule
bind hcc_chain hcc_chain_props hcc_chain_props_inst (
    .clk_i(clk_i), .srst_i(srst_i), .sat_rx_data_i(sat_rx_data_i), .sat_tx_enable_o(sat_tx_enable_o),
    .center_tx_enable_o(center_tx_enable_o), .cascade_clock_out_b_o(cascade_clock_out_b_o),
    .fwd_in_i(fwd_in_i), .fwd_out_o(fwd_out_o), .rev_out_o(rev_out_o),
    .rx_monitor_n_o(rx_monitor_n_o), .is_top_o(is_top_o));
`default_nettype wire
